//--- design/pms_core.sv
// Power mode selection, module standby and converter interrupt registers on Wishbone
// Functional notes
// - Enable bit five gates converter interrupts
// - Conversion done sets request bit five
// - Writing zero clears flag; one ignored
// - Deep sleep bit picks standby or sleep
// - Low speed bit picks subclock after watch
// - Direct transfer joins selectors for target mode
// - Middle speed bit picks resume speed
// - Clock stop zero stops module, resets one
// - First clock stop register bit assignment
// - Bit three stops delta sigma converter
// - Serial three standby resets its registers
// - Masked ROM hides first register bit seven
//
// Local design decision: register access over Wishbone.
module pms_core
  import pms_pkg::*;
#(
  parameter int ADR_W = 18,
  parameter bit MASKED_ROM = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ds_conv_done_i,
  input wire logic sleep_exec_i,
  input wire logic timer_mode_select_bit_i,
  output logic ds_irq_o,
  output logic irq_o,
  output logic [7:0] clk_run_one_o,
  output logic [7:0] clk_run_two_o,
  output logic serial_three_reset_o,
  output pms_target_type target_o
);

  // Refuse an address bus too narrow for the sixteen bit register index
  if (ADR_W < 18) begin : g_adr_check
    $error("pms_core: ADR_W must be at least 18");
  end


  logic ack_q;
  logic [31:0] rdata_q;
  logic ds_conv_irq_enable_q;
  logic ds_conv_done_flag_q;
  logic ds_conv_done_flag_d;
  logic deep_sleep_select_q;
  logic low_speed_resume_q;
  logic direct_transfer_select_q;
  logic middle_speed_resume_q;
  logic [7:0] clk_stop_one_q;
  logic [7:0] clk_stop_two_q;
  logic [PMS_EVT_W-1:0] evt_status_q;
  logic [PMS_EVT_W-1:0] evt_status_d;
  logic [PMS_EVT_W-1:0] evt_mask_q;
  logic [PMS_EVT_W-1:0] evt_raise;
  logic ds_irq_q;
  logic irq_q;
  logic [7:0] run_one_q;
  logic serial_three_reset_q;
  pms_target_type target_q;
  pms_mode_type mode_sel;
  logic [15:0] idx;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign idx = adr_i[17:2];
  assign wbyte = dat_i[7:0];
  // A write lands on the edge at which the master sees ack
  assign wr_fire = cyc_i && stb_i && we_i && ack_q && sel_i[0];

  // Bus answer: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  always_comb begin
    rbyte = 8'h00;
    case (idx)
      PMS_IDX_SYSCTL_ONE: begin
        rbyte[PMS_BIT_DEEP_SLEEP] = deep_sleep_select_q;
        rbyte[PMS_BIT_LOW_SPEED] = low_speed_resume_q;
      end
      PMS_IDX_SYSCTL_TWO: begin
        rbyte[PMS_BIT_DIRECT] = direct_transfer_select_q;
        rbyte[PMS_BIT_MID_SPEED] = middle_speed_resume_q;
      end
      PMS_IDX_IRQ_EN_TWO: begin
        rbyte[PMS_BIT_DS_CONV] = ds_conv_irq_enable_q;
      end
      PMS_IDX_IRQ_REQ_TWO: begin
        rbyte[PMS_BIT_DS_CONV] = ds_conv_done_flag_q;
      end
      PMS_IDX_CLK_STOP_ONE: begin
        rbyte = clk_stop_one_q;
        if (MASKED_ROM) begin
          rbyte[PMS_BIT_SERIAL_FOUR] = 1'b0;
        end
      end
      PMS_IDX_CLK_STOP_TWO: begin
        rbyte = clk_stop_two_q;
      end
      PMS_IDX_EVT_STATUS: begin
        rbyte[PMS_EVT_W-1:0] = evt_status_q;
      end
      PMS_IDX_EVT_MASK: begin
        rbyte[PMS_EVT_W-1:0] = evt_mask_q;
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= {24'h00_0000, rbyte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ds_conv_irq_enable_q <= PMS_RST_CTRL[PMS_BIT_DS_CONV];
    end else if (wr_fire && idx == PMS_IDX_IRQ_EN_TWO) begin
      ds_conv_irq_enable_q <= wbyte[PMS_BIT_DS_CONV];
    end
  end

  always_comb begin
    ds_conv_done_flag_d = ds_conv_done_flag_q;
    if (wr_fire && idx == PMS_IDX_IRQ_REQ_TWO && !wbyte[PMS_BIT_DS_CONV]) begin
      ds_conv_done_flag_d = 1'b0;
    end
    if (ds_conv_done_i) begin
      ds_conv_done_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ds_conv_done_flag_q <= PMS_RST_CTRL[PMS_BIT_DS_CONV];
    end else begin
      ds_conv_done_flag_q <= ds_conv_done_flag_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ds_irq_q <= 1'b0;
    end else begin
      ds_irq_q <= ds_conv_done_flag_q && ds_conv_irq_enable_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep_sleep_select_q <= PMS_RST_CTRL[PMS_BIT_DEEP_SLEEP];
      low_speed_resume_q <= PMS_RST_CTRL[PMS_BIT_LOW_SPEED];
    end else if (wr_fire && idx == PMS_IDX_SYSCTL_ONE) begin
      deep_sleep_select_q <= wbyte[PMS_BIT_DEEP_SLEEP];
      low_speed_resume_q <= wbyte[PMS_BIT_LOW_SPEED];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      direct_transfer_select_q <= PMS_RST_CTRL[PMS_BIT_DIRECT];
      middle_speed_resume_q <= PMS_RST_CTRL[PMS_BIT_MID_SPEED];
    end else if (wr_fire && idx == PMS_IDX_SYSCTL_TWO) begin
      direct_transfer_select_q <= wbyte[PMS_BIT_DIRECT];
      middle_speed_resume_q <= wbyte[PMS_BIT_MID_SPEED];
    end
  end

  always_comb begin
    mode_sel = PMS_MODE_SLEEP;
    if (direct_transfer_select_q) begin
      mode_sel = PMS_MODE_DIRECT;
    end else if (deep_sleep_select_q) begin
      mode_sel = timer_mode_select_bit_i ? PMS_MODE_WATCH : PMS_MODE_STANDBY;
    end else begin
      mode_sel = low_speed_resume_q ? PMS_MODE_SUBSLEEP : PMS_MODE_SLEEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_q <= '{mode: PMS_MODE_ACTIVE, sub_clock: 1'b0, mid_speed: 1'b0};
    end else if (sleep_exec_i) begin
      target_q.mode <= mode_sel;
      target_q.sub_clock <= low_speed_resume_q;
      target_q.mid_speed <= middle_speed_resume_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_stop_one_q <= PMS_RST_CLK_STOP;
      clk_stop_two_q <= PMS_RST_CLK_STOP;
    end else if (wr_fire && idx == PMS_IDX_CLK_STOP_ONE) begin
      clk_stop_one_q <= wbyte;
      if (MASKED_ROM) begin
        clk_stop_one_q[PMS_BIT_SERIAL_FOUR] <= PMS_RST_CLK_STOP[PMS_BIT_SERIAL_FOUR];
      end
    end else if (wr_fire && idx == PMS_IDX_CLK_STOP_TWO) begin
      clk_stop_two_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_one_q <= PMS_RST_CLK_STOP;
    end else begin
      run_one_q <= clk_stop_one_q;
      if (MASKED_ROM) begin
        run_one_q[PMS_BIT_SERIAL_FOUR] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_three_reset_q <= 1'b0;
    end else begin
      serial_three_reset_q <= !(clk_stop_one_q[PMS_BIT_SERIAL_3CH1]
                                && clk_stop_one_q[PMS_BIT_SERIAL_3CH2]);
    end
  end

  // Event status, set wins over write one to clear
  assign evt_raise = {sleep_exec_i, ds_conv_done_i};
  genvar g;
  generate
    for (g = 0; g < PMS_EVT_W; g++) begin : g_evt
      assign evt_status_d[g] = evt_raise[g] || (evt_status_q[g]
        && !(wr_fire && idx == PMS_IDX_EVT_STATUS && wbyte[g]));
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_status_q <= PMS_RST_EVT;
    end else begin
      evt_status_q <= evt_status_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_mask_q <= PMS_RST_EVT;
    end else if (wr_fire && idx == PMS_IDX_EVT_MASK) begin
      evt_mask_q <= wbyte[PMS_EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_status_q & evt_mask_q);
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdata_q;
  assign ds_irq_o = ds_irq_q;
  assign irq_o = irq_q;
  assign clk_run_one_o = run_one_q;
  assign clk_run_two_o = clk_stop_two_q;
  assign serial_three_reset_o = serial_three_reset_q;
  assign target_o = target_q;

  // Checks
  sequence s_zero_write_flag;
    wr_fire && idx == PMS_IDX_IRQ_REQ_TWO && !wbyte[PMS_BIT_DS_CONV] && !ds_conv_done_i;
  endsequence

  sequence s_one_write_flag;
    wr_fire && idx == PMS_IDX_IRQ_REQ_TWO && wbyte[PMS_BIT_DS_CONV];
  endsequence

  sequence s_enable_and_flag;
    ds_conv_done_flag_q && ds_conv_irq_enable_q;
  endsequence

  done_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ds_conv_done_i |=> ds_conv_done_flag_q)
    else $error("conversion done did not set flag");

  zero_clears_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_zero_write_flag |=> !ds_conv_done_flag_q)
    else $error("zero write did not clear flag");

  one_keeps_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_one_write_flag |=> (ds_conv_done_flag_q == $past(ds_conv_done_flag_q))
      || $past(ds_conv_done_i))
    else $error("one write changed flag");

  ds_irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ds_irq_o == $past(ds_conv_done_flag_q && ds_conv_irq_enable_q))
    else $error("converter request wrong");

  enable_gates_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ds_conv_irq_enable_q [*2] |-> !ds_irq_o)
    else $error("request while disabled");

  request_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_enable_and_flag ##1 s_enable_and_flag |-> ds_irq_o)
    else $error("request missing");

  deep_sleep_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_exec_i && deep_sleep_select_q && !direct_transfer_select_q |=>
      target_o.mode inside {PMS_MODE_STANDBY, PMS_MODE_WATCH})
    else $error("deep sleep target wrong");

  direct_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_exec_i && direct_transfer_select_q |=> target_o.mode == PMS_MODE_DIRECT)
    else $error("direct target wrong");

  resume_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_exec_i |=> target_o.mid_speed == $past(middle_speed_resume_q)
      && target_o.sub_clock == $past(low_speed_resume_q))
    else $error("resume clock wrong");

  ds_clock_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_stop_one_q[PMS_BIT_DS_CLK] |=> !clk_run_one_o[PMS_BIT_DS_CLK])
    else $error("converter clock not stopped");

  serial_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_stop_one_q[PMS_BIT_SERIAL_3CH1] || !clk_stop_one_q[PMS_BIT_SERIAL_3CH2]
      |=> serial_three_reset_o)
    else $error("serial three reset missing");

  run_follows_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 clk_run_one_o[6:0] == $past(clk_stop_one_q[6:0]))
    else $error("clock enables wrong");

  reserved_hidden_a: assert property (@(posedge clk_i) disable iff (rst_i)
    MASKED_ROM && ack_o && idx == PMS_IDX_CLK_STOP_ONE |-> !dat_o[PMS_BIT_SERIAL_FOUR])
    else $error("reserved bit visible");

  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");

endmodule : pms_core

//--- pkg/pms_pkg.sv
// Register map, field positions, reset values and shared types of the power mode block
package pms_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [15:0] PMS_IDX_SYSCTL_ONE = 16'hfff0;
  localparam logic [15:0] PMS_IDX_SYSCTL_TWO = 16'hfff1;
  localparam logic [15:0] PMS_IDX_IRQ_EN_TWO = 16'hfff4;
  localparam logic [15:0] PMS_IDX_IRQ_REQ_TWO = 16'hfff7;
  localparam logic [15:0] PMS_IDX_CLK_STOP_ONE = 16'hfffa;
  localparam logic [15:0] PMS_IDX_CLK_STOP_TWO = 16'hfffb;
  localparam logic [15:0] PMS_IDX_EVT_STATUS = 16'hffe0;
  localparam logic [15:0] PMS_IDX_EVT_MASK = 16'hffe1;

  // Field positions
  localparam int PMS_BIT_DS_CONV = 5;
  localparam int PMS_BIT_DEEP_SLEEP = 7;
  localparam int PMS_BIT_LOW_SPEED = 3;
  localparam int PMS_BIT_DIRECT = 3;
  localparam int PMS_BIT_MID_SPEED = 2;
  localparam int PMS_BIT_SERIAL_FOUR = 7;
  localparam int PMS_BIT_SERIAL_3CH1 = 6;
  localparam int PMS_BIT_SERIAL_3CH2 = 5;
  localparam int PMS_BIT_DS_CLK = 3;
  localparam int PMS_EVT_CONV_DONE = 0;
  localparam int PMS_EVT_SLEEP = 1;
  localparam int PMS_EVT_W = 2;

  // Reset values
  localparam logic [7:0] PMS_RST_CTRL = 8'h00;
  localparam logic [7:0] PMS_RST_CLK_STOP = 8'hff;
  localparam logic [PMS_EVT_W-1:0] PMS_RST_EVT = 2'h0;

  typedef enum logic [2:0] {
    PMS_MODE_ACTIVE = 3'b000,
    PMS_MODE_SLEEP = 3'b001,
    PMS_MODE_SUBSLEEP = 3'b010,
    PMS_MODE_STANDBY = 3'b011,
    PMS_MODE_WATCH = 3'b100,
    PMS_MODE_DIRECT = 3'b101
  } pms_mode_type;

  // Target of a sleep instruction and the clock used once it ends
  typedef struct packed {
    pms_mode_type mode;
    logic sub_clock;
    logic mid_speed;
  } pms_target_type;
endpackage : pms_pkg

//--- verif/test_power_mode_and_module_standby.sv
// Self-checking bench for the power mode and module standby register block
module test_power_mode_and_module_standby import pms_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0;
  logic stb_i = 1'h0;
  logic we_i = 1'h0;
  logic [17:0] adr_i = 18'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic ds_conv_done_i = 1'h0;
  logic sleep_exec_i = 1'h0;
  logic timer_mode_select_bit_i = 1'h0;
  logic [31:0] dat_o;
  logic [31:0] rom_dat_o;
  logic ack_o;
  logic ds_irq_o;
  logic irq_o;
  logic [7:0] clk_run_one_o;
  logic [7:0] clk_run_two_o;
  logic [7:0] rom_run_one_o;
  logic serial_three_reset_o;
  pms_target_type target_o;
  pms_target_type exp_t;
  logic [31:0] rd;
  logic [31:0] rom_rd;
  logic [7:0] pat;
  logic [4:0] m;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] ridx [8] = '{PMS_IDX_SYSCTL_ONE, PMS_IDX_SYSCTL_TWO, PMS_IDX_IRQ_EN_TWO,
    PMS_IDX_IRQ_REQ_TWO, PMS_IDX_CLK_STOP_ONE, PMS_IDX_CLK_STOP_TWO, PMS_IDX_EVT_STATUS,
    PMS_IDX_EVT_MASK};
  logic [7:0] rval [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};

  always #10 clk_i = ~clk_i;

  pms_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ds_conv_done_i(ds_conv_done_i), .sleep_exec_i(sleep_exec_i),
    .timer_mode_select_bit_i(timer_mode_select_bit_i), .ds_irq_o(ds_irq_o), .irq_o(irq_o),
    .clk_run_one_o(clk_run_one_o), .clk_run_two_o(clk_run_two_o),
    .serial_three_reset_o(serial_three_reset_o), .target_o(target_o));

  // Variant with the top serial stop bit hidden
  pms_core #(.MASKED_ROM(1'h1)) dut_rom_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(rom_dat_o), .ack_o(), .ds_conv_done_i(ds_conv_done_i),
    .sleep_exec_i(sleep_exec_i), .timer_mode_select_bit_i(timer_mode_select_bit_i),
    .ds_irq_o(), .irq_o(), .clk_run_one_o(rom_run_one_o), .clk_run_two_o(),
    .serial_three_reset_o(), .target_o());

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t data %h expected %h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_target(input pms_target_type got, input pms_target_type exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t target %h expected %h", $time, got, exp);
    end
  endtask : check_target

  // Classic single cycle; held until ack is sampled high
  task automatic wb_cycle(input logic wr, input logic [15:0] idx, input logic [7:0] wdat,
                          input logic [3:0] sel);
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= wr;
    adr_i <= {idx, 2'h0};
    sel_i <= sel;
    dat_i <= {24'h0, wdat};
    @(posedge clk_i);
    while (ack_o !== 1'h1) @(posedge clk_i);
    rd = dat_o;
    rom_rd = rom_dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i <= 1'h0;
  endtask : wb_cycle

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    wb_cycle(1'h1, idx, d, 4'h1);
  endtask : wr

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    wb_cycle(1'h0, idx, 8'h00, 4'h1);
    check_data(rd, {24'h0, exp});
  endtask : rd_chk

  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic pulse(input int which);
    @(posedge clk_i);
    if (which == 0) ds_conv_done_i <= 1'h1;
    else sleep_exec_i <= 1'h1;
    @(posedge clk_i);
    ds_conv_done_i <= 1'h0;
    sleep_exec_i <= 1'h0;
    settle();
  endtask : pulse

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 8; i++) rd_chk(ridx[i], rval[i]);
    rd_chk(16'h1234, 8'h00);
    wr(16'h1234, 8'hff);
    rd_chk(16'h1234, 8'h00);
    wr(PMS_IDX_CLK_STOP_ONE, 8'hff);
    settle();
    check_data({24'h0, rom_run_one_o}, 32'h7f);
    wb_cycle(1'h0, PMS_IDX_CLK_STOP_ONE, 8'h00, 4'h1);
    check_data(rom_rd, 32'h7f);
    for (int i = 0; i < 8; i++) begin
      pat = ~(8'h01 << i);
      wr(PMS_IDX_CLK_STOP_ONE, pat);
      settle();
      check_data({24'h0, clk_run_one_o}, {24'h0, pat});
      check_bit(serial_three_reset_o, 1'(i == 5 || i == 6));
      rd_chk(PMS_IDX_CLK_STOP_ONE, pat);
    end
    wr(PMS_IDX_CLK_STOP_ONE, 8'hff);
    settle();
    check_data({24'h0, clk_run_one_o}, 32'hff);
    check_bit(serial_three_reset_o, 1'h0);
    wr(PMS_IDX_CLK_STOP_TWO, 8'h5a);
    wb_cycle(1'h1, PMS_IDX_CLK_STOP_TWO, 8'h00, 4'he);
    settle();
    check_data({24'h0, clk_run_two_o}, 32'h5a);
    rd_chk(PMS_IDX_CLK_STOP_TWO, 8'h5a);
    pulse(0);
    rd_chk(PMS_IDX_IRQ_REQ_TWO, 8'h20);
    check_bit(ds_irq_o, 1'h0);
    wr(PMS_IDX_IRQ_EN_TWO, 8'h20);
    settle();
    check_bit(ds_irq_o, 1'h1);
    wr(PMS_IDX_IRQ_REQ_TWO, 8'h20);
    rd_chk(PMS_IDX_IRQ_REQ_TWO, 8'h20);
    wr(PMS_IDX_IRQ_REQ_TWO, 8'h00);
    settle();
    rd_chk(PMS_IDX_IRQ_REQ_TWO, 8'h00);
    check_bit(ds_irq_o, 1'h0);
    pulse(0);
    wr(PMS_IDX_IRQ_EN_TWO, 8'h00);
    settle();
    check_bit(ds_irq_o, 1'h0);
    wr(PMS_IDX_EVT_STATUS, 8'h03);
    rd_chk(PMS_IDX_EVT_STATUS, 8'h00);
    pulse(0);
    rd_chk(PMS_IDX_EVT_STATUS, 8'h01);
    check_bit(irq_o, 1'h0);
    wr(PMS_IDX_EVT_MASK, 8'h01);
    settle();
    check_bit(irq_o, 1'h1);
    wr(PMS_IDX_EVT_STATUS, 8'h01);
    settle();
    check_bit(irq_o, 1'h0);
    pulse(1);
    rd_chk(PMS_IDX_EVT_STATUS, 8'h02);
    wr(PMS_IDX_EVT_MASK, 8'h02);
    settle();
    check_bit(irq_o, 1'h1);
    wr(PMS_IDX_EVT_MASK, 8'h00);
    settle();
    check_bit(irq_o, 1'h0);
    // Every combination of the selector bits and the timer level
    for (int k = 0; k < 32; k++) begin
      m = 5'(k);
      wr(PMS_IDX_SYSCTL_ONE, {m[0], 3'h0, m[1], 3'h0});
      wr(PMS_IDX_SYSCTL_TWO, {4'h0, m[2], m[3], 2'h0});
      timer_mode_select_bit_i <= m[4];
      pulse(1);
      exp_t.mode = m[2] ? PMS_MODE_DIRECT : m[0] ? (m[4] ? PMS_MODE_WATCH : PMS_MODE_STANDBY)
                   : (m[1] ? PMS_MODE_SUBSLEEP : PMS_MODE_SLEEP);
      exp_t.sub_clock = m[1];
      exp_t.mid_speed = m[3];
      check_target(target_o, exp_t);
    end
    rd_chk(PMS_IDX_SYSCTL_ONE, 8'h88);
    rd_chk(PMS_IDX_SYSCTL_TWO, 8'h0c);
    print_verdict();
  end
endmodule : test_power_mode_and_module_standby
